// ### core/lrsd_decode.sv
/*
 Legacy low-memory decoder with fixed hole and compatible SMM RAM control.
 Assumes host requests are one-cycle strobes synchronous to core_clk and
 that the configuration master never stalls.
*/
// Function
// - Lowest 512 KB always goes to DRAM
// - 80000-9FFFF to DRAM unless hole declared
// - Video buffer ignores attributes, goes PCI/AGP
// - Video PCI or AGP by VGA enable
// - SMM video range refused to hub/AGP
// - C0000-DFFFF eight 16 KB attribute segments
// - E0000-EFFFF four 16 KB attribute segments
// - F0000-FFFFF one 64 KB attribute segment
// - Hole enable removes 15-16 MB from DRAM
// - DRAM under hole is never relocated
// - Open, closed, lock act only when enabled
// - Open and unlocked exposes SMM RAM to every host cycle
// - Closed denies data, allows code references
// - Lock clears open, freezes locked fields
// - Lock clears only on full reset
// - Global enable maps SMM RAM at A0000
// - Base segment reads fixed 010
// - SMM RAM unmapped, else forwarded to hub
// - Read/write claim attributes choose DRAM/PCI
`timescale 1ns/10ps
`default_nettype none
module lrsd_decode (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    input wire logic vga_to_agp,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic req_smm,
    input wire logic req_code,
    input wire logic req_from_host,
    output logic rsp_valid,
    output lrsd_pkg::lrsd_route_t rsp_route
);
    logic [7:0] seg_attr [7];
    logic hole_enable;
    logic smm_space_open;
    logic smm_space_closed;
    logic smm_space_locked;
    logic global_smm_ram_enable;
    logic [7:0] next_rdata;
    lrsd_pkg::lrsd_route_t next_route;
    logic [3:0] claim_nib;
    logic claim;
    logic smm_ok;
    logic in_video;

    // Segment attribute registers, reserved nibble bits held at zero
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_attr
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    seg_attr[gi] <= lrsd_pkg::SEG_ATTR_RESET;
                end else if (cfg_wr && cfg_addr ==
                             lrsd_pkg::SEG_ATTR_BASE + 8'(gi)) begin
                    seg_attr[gi] <= cfg_wdata & 8'h33;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hole_enable <= lrsd_pkg::FHC_RESET[lrsd_pkg::HOLE_EN_BIT];
        end else if (cfg_wr && cfg_addr == lrsd_pkg::FHC_OFFSET) begin
            hole_enable <= cfg_wdata[lrsd_pkg::HOLE_EN_BIT];
        end
    end

    // Lock is sticky; only the synchronous reset can clear it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            smm_space_locked <= lrsd_pkg::SMC_RESET[lrsd_pkg::LOCK_BIT];
        end else if (cfg_wr && cfg_addr == lrsd_pkg::SMC_OFFSET &&
                     cfg_wdata[lrsd_pkg::LOCK_BIT]) begin
            smm_space_locked <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            smm_space_open <= lrsd_pkg::SMC_RESET[lrsd_pkg::OPEN_BIT];
            global_smm_ram_enable <=
                lrsd_pkg::SMC_RESET[lrsd_pkg::GSMRAM_BIT];
            smm_space_closed <= lrsd_pkg::SMC_RESET[lrsd_pkg::CLOSED_BIT];
        end else if (cfg_wr && cfg_addr == lrsd_pkg::SMC_OFFSET) begin
            smm_space_closed <= cfg_wdata[lrsd_pkg::CLOSED_BIT];
            if (!smm_space_locked) begin
                // Writing lock in the same write still kills open
                smm_space_open <= cfg_wdata[lrsd_pkg::OPEN_BIT] &&
                    !cfg_wdata[lrsd_pkg::LOCK_BIT];
                global_smm_ram_enable <=
                    cfg_wdata[lrsd_pkg::GSMRAM_BIT];
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (cfg_addr >= lrsd_pkg::SEG_ATTR_BASE &&
            cfg_addr <= lrsd_pkg::SEG_ATTR_LAST) begin
            next_rdata = seg_attr[3'(cfg_addr - lrsd_pkg::SEG_ATTR_BASE)];
        end else if (cfg_addr == lrsd_pkg::FHC_OFFSET) begin
            next_rdata[lrsd_pkg::HOLE_EN_BIT] = hole_enable;
        end else if (cfg_addr == lrsd_pkg::SMC_OFFSET) begin
            next_rdata[lrsd_pkg::OPEN_BIT] = smm_space_open;
            next_rdata[lrsd_pkg::CLOSED_BIT] = smm_space_closed;
            next_rdata[lrsd_pkg::LOCK_BIT] = smm_space_locked;
            next_rdata[lrsd_pkg::GSMRAM_BIT] = global_smm_ram_enable;
            next_rdata[2:0] = lrsd_pkg::COMPAT_BASE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            cfg_rdata <= next_rdata;
        end else begin
            cfg_rdata <= 8'h00;
        end
    end

    // Pick the attribute nibble for the 16 KB or 64 KB segment
    always_comb begin
        claim_nib = 4'h0;
        if (req_addr[19:16] == 4'hF) begin
            claim_nib = seg_attr[0][7:4];
        end else if (req_addr[19:18] == 2'b11) begin
            // C0000-EFFFF: two 16 KB segments per register
            claim_nib = req_addr[14] ?
                seg_attr[3'(req_addr[17:15]) + 3'h1][7:4] :
                seg_attr[3'(req_addr[17:15]) + 3'h1][3:0];
        end
    end

    assign claim = req_write ? claim_nib[1] : claim_nib[0];
    assign in_video = req_addr > lrsd_pkg::DOS_HIGH_TOP &&
                      req_addr <= lrsd_pkg::VIDEO_TOP;
    // Disabled SMM RAM ignores open/closed/lock entirely
    assign smm_ok = global_smm_ram_enable &&
        ((smm_space_open && !smm_space_locked) ||
         (req_smm && (req_code || !smm_space_closed)));

    always_comb begin
        next_route = lrsd_pkg::LRSD_PCI;
        if (req_addr <= lrsd_pkg::DOS_LOW_TOP) begin
            next_route = lrsd_pkg::LRSD_DRAM;
        end else if (req_addr <= lrsd_pkg::DOS_HIGH_TOP) begin
            next_route = hole_enable ? lrsd_pkg::LRSD_PCI :
                                       lrsd_pkg::LRSD_DRAM;
        end else if (in_video) begin
            if (!req_from_host) begin
                next_route = global_smm_ram_enable ?
                    lrsd_pkg::LRSD_REFUSE : lrsd_pkg::LRSD_PCI;
            end else if (smm_ok) begin
                next_route = lrsd_pkg::LRSD_DRAM;
            end else begin
                next_route = vga_to_agp ? lrsd_pkg::LRSD_AGP :
                                          lrsd_pkg::LRSD_PCI;
            end
        end else if (req_addr < lrsd_pkg::ONE_MB) begin
            // Non-host initiators always hit DRAM in attribute areas
            next_route = (!req_from_host || claim) ?
                lrsd_pkg::LRSD_DRAM : lrsd_pkg::LRSD_PCI;
        end else if (hole_enable && req_addr >= lrsd_pkg::HOLE_LO &&
                     req_addr <= lrsd_pkg::HOLE_HI) begin
            next_route = lrsd_pkg::LRSD_PCI;
        end else begin
            next_route = lrsd_pkg::LRSD_DRAM;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_route <= lrsd_pkg::LRSD_DRAM;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_route <= next_route;
            end
        end
    end

    property p_low_dram;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_addr <= lrsd_pkg::DOS_LOW_TOP |=>
            rsp_valid && rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_low_dram: assert property (p_low_dram)
        else $error("low 512 KB not routed to DRAM");

    property p_dos_hole;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_addr > lrsd_pkg::DOS_LOW_TOP &&
        req_addr <= lrsd_pkg::DOS_HIGH_TOP |=>
            rsp_route == ($past(hole_enable) ? lrsd_pkg::LRSD_PCI :
                          lrsd_pkg::LRSD_DRAM);
    endproperty
    a_dos_hole: assert property (p_dos_hole)
        else $error("upper DOS area misrouted");

    property p_hub_refused;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && !req_from_host &&
        global_smm_ram_enable |=> rsp_route == lrsd_pkg::LRSD_REFUSE;
    endproperty
    a_hub_refused: assert property (p_hub_refused)
        else $error("SMM video range not refused to hub or AGP");

    property p_vga_agp;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host && !req_smm &&
        !smm_space_open |=>
            rsp_route == ($past(vga_to_agp) ? lrsd_pkg::LRSD_AGP :
                          lrsd_pkg::LRSD_PCI);
    endproperty
    a_vga_agp: assert property (p_vga_agp)
        else $error("video buffer PCI/AGP choice wrong");

    property p_high_hole;
        @(posedge core_clk) disable iff (rst)
        req_valid && hole_enable && req_addr >= lrsd_pkg::HOLE_LO &&
        req_addr <= lrsd_pkg::HOLE_HI |=>
            rsp_route != lrsd_pkg::LRSD_DRAM;
    endproperty
    a_high_hole: assert property (p_high_hole)
        else $error("15-16 MB hole decoded to DRAM");

    property p_lock_sticky;
        @(posedge core_clk) disable iff (rst)
        smm_space_locked |=> smm_space_locked && !smm_space_open;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock cleared or open set while locked");

    property p_lock_freezes;
        @(posedge core_clk) disable iff (rst)
        smm_space_locked |=> $stable(global_smm_ram_enable);
    endproperty
    a_lock_freezes: assert property (p_lock_freezes)
        else $error("locked field changed");

    property p_closed_data;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host && req_smm && !req_code &&
        smm_space_closed && !smm_space_open |=>
            rsp_route != lrsd_pkg::LRSD_DRAM;
    endproperty
    a_closed_data: assert property (p_closed_data)
        else $error("closed SMM space gave data access");

    property p_base_seg;
        @(posedge core_clk) disable iff (rst)
        cfg_rd && cfg_addr == lrsd_pkg::SMC_OFFSET |=>
            cfg_rdata[2:0] == lrsd_pkg::COMPAT_BASE && !cfg_rdata[7];
    endproperty
    a_base_seg: assert property (p_base_seg)
        else $error("SMM control readback wrong");

    property p_gsmram_off;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host &&
        !global_smm_ram_enable |=> rsp_route != lrsd_pkg::LRSD_DRAM;
    endproperty
    a_gsmram_off: assert property (p_gsmram_off)
        else $error("SMM RAM visible while disabled");

    property p_video_no_attr;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host &&
        !global_smm_ram_enable |=>
            rsp_route == ($past(vga_to_agp) ? lrsd_pkg::LRSD_AGP :
                          lrsd_pkg::LRSD_PCI);
    endproperty
    a_video_no_attr: assert property (p_video_no_attr)
        else $error("video buffer not sent to PCI or AGP");

    property p_smm_open;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host && global_smm_ram_enable &&
        smm_space_open && !smm_space_locked |=>
            rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_smm_open: assert property (p_smm_open)
        else $error("open SMM space not visible");

    property p_smm_map;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host && global_smm_ram_enable &&
        req_smm && !smm_space_closed |=>
            rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_smm_map: assert property (p_smm_map)
        else $error("SMM cycle missed SMM RAM");

    property p_code_ref;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host && global_smm_ram_enable &&
        req_smm && req_code |=> rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_code_ref: assert property (p_code_ref)
        else $error("SMM code reference refused");

    property p_smm_forward;
        @(posedge core_clk) disable iff (rst)
        req_valid && in_video && req_from_host && !req_smm &&
        !smm_space_open |=> rsp_route != lrsd_pkg::LRSD_DRAM;
    endproperty
    a_smm_forward: assert property (p_smm_forward)
        else $error("non-SMM cycle reached SMM RAM");

    property p_bios_read;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_from_host && !req_write && seg_attr[0][4] &&
        req_addr[31:16] == 16'h000F |=> rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_bios_read: assert property (p_bios_read)
        else $error("BIOS segment read not claimed");

    property p_bios_write;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_from_host && req_write && !seg_attr[0][5] &&
        req_addr[31:16] == 16'h000F |=> rsp_route == lrsd_pkg::LRSD_PCI;
    endproperty
    a_bios_write: assert property (p_bios_write)
        else $error("unclaimed BIOS write reached DRAM");

    property p_exp_low;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_from_host && !req_write && seg_attr[1][0] &&
        req_addr[31:14] == 18'h00030 |=> rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_exp_low: assert property (p_exp_low)
        else $error("first expansion segment read not claimed");

    property p_exp_high;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_from_host && req_write && !seg_attr[1][5] &&
        req_addr[31:14] == 18'h00031 |=> rsp_route == lrsd_pkg::LRSD_PCI;
    endproperty
    a_exp_high: assert property (p_exp_high)
        else $error("second expansion segment write misrouted");

    property p_ext_bios;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_from_host && req_write && seg_attr[6][5] &&
        req_addr[31:14] == 18'h0003B |=> rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_ext_bios: assert property (p_ext_bios)
        else $error("last extended BIOS segment write not claimed");

    property p_above_dram;
        @(posedge core_clk) disable iff (rst)
        req_valid && req_addr >= lrsd_pkg::ONE_MB && !(hole_enable &&
        req_addr >= lrsd_pkg::HOLE_LO && req_addr <= lrsd_pkg::HOLE_HI) |=>
            rsp_route == lrsd_pkg::LRSD_DRAM;
    endproperty
    a_above_dram: assert property (p_above_dram)
        else $error("memory above 1 MB relocated or forwarded");

    property p_fhc_reserved;
        @(posedge core_clk) disable iff (rst)
        cfg_rd && cfg_addr == lrsd_pkg::FHC_OFFSET |=>
            cfg_rdata[6:0] == 7'h00;
    endproperty
    a_fhc_reserved: assert property (p_fhc_reserved)
        else $error("hole control reserved bits not zero");

    property p_lock_write;
        @(posedge core_clk) disable iff (rst)
        cfg_wr && cfg_addr == lrsd_pkg::SMC_OFFSET &&
        cfg_wdata[lrsd_pkg::LOCK_BIT] |=>
            smm_space_locked && !smm_space_open;
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("lock write left SMM space open");
endmodule
`default_nettype wire

// ### core/lrsd_pkg.sv
/*
 Constants for the legacy region and compatible SMM RAM decoder.
 Assumes a byte-wide configuration port addressed by register offset.
*/
package lrsd_pkg;
    localparam logic [7:0] FHC_OFFSET = 8'h97;
    localparam logic [7:0] SMC_OFFSET = 8'h9D;
    localparam logic [7:0] SEG_ATTR_BASE = 8'h90;
    localparam logic [7:0] SEG_ATTR_LAST = 8'h96;
    localparam logic [7:0] FHC_RESET = 8'h00;
    localparam logic [7:0] SMC_RESET = 8'h02;
    localparam logic [7:0] SEG_ATTR_RESET = 8'h00;
    localparam int HOLE_EN_BIT = 7;
    localparam int OPEN_BIT = 6;
    localparam int CLOSED_BIT = 5;
    localparam int LOCK_BIT = 4;
    localparam int GSMRAM_BIT = 3;
    localparam logic [2:0] COMPAT_BASE = 3'h2;
    localparam logic [31:0] DOS_LOW_TOP = 32'h0007FFFF;
    localparam logic [31:0] DOS_HIGH_TOP = 32'h0009FFFF;
    localparam logic [31:0] VIDEO_TOP = 32'h000BFFFF;
    localparam logic [31:0] EXP_TOP = 32'h000DFFFF;
    localparam logic [31:0] EXTB_TOP = 32'h000EFFFF;
    localparam logic [31:0] ONE_MB = 32'h00100000;
    localparam logic [31:0] HOLE_LO = 32'h00F00000;
    localparam logic [31:0] HOLE_HI = 32'h00FFFFFF;
    typedef enum logic [1:0] {
        LRSD_DRAM,
        LRSD_PCI,
        LRSD_AGP,
        LRSD_REFUSE
    } lrsd_route_t;
endpackage

// ### tb/lrsd_host_model.sv
/*
 Host-side request source for the legacy decoder bench.
 Assumes it shares core_clk with the decoder; one request at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module lrsd_host_model (
    input wire logic core_clk,
    input wire logic rsp_valid,
    input wire lrsd_pkg::lrsd_route_t rsp_route,
    output logic req_valid,
    output logic [31:0] req_addr,
    output logic req_write,
    output logic req_smm,
    output logic req_code,
    output logic req_from_host
);
    initial begin
        req_valid = 1'b0;
        req_addr = 32'h00000000;
        {req_write, req_smm, req_code, req_from_host} = 4'h0;
    end
    // Flag bits f: write, smm, code, host
    task automatic issue(input logic [31:0] a, input logic [3:0] f,
            output lrsd_pkg::lrsd_route_t r, output logic ok);
        int i;
        ok = 1'b0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_addr <= a;
        {req_write, req_smm, req_code, req_from_host} <= f;
        @(posedge core_clk);
        req_valid <= 1'b0;
        // Released lines show junk so stale values cannot pass
        req_addr <= ~a;
        {req_write, req_smm, req_code, req_from_host} <= ~f;
        for (i = 0; i < 4 && !ok; i++) begin
            @(posedge core_clk);
            if (rsp_valid === 1'b1) begin
                ok = 1'b1;
                r = rsp_route;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### tb/lrsd_decode_tb.sv
/*
 Random and corner-case bench for the legacy decoder against a mirror.
 Assumes lrsd_pkg and the host model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module lrsd_decode_tb;
    logic core_clk, rst, cfg_wr, cfg_rd, vga_to_agp;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, hole, smc;
    logic [7:0] attr [7];
    logic req_valid, req_write, req_smm, req_code, req_from_host, rsp_valid;
    logic [31:0] req_addr;
    lrsd_pkg::lrsd_route_t rsp_route;
    int bad_count, n_compared;
    logic [31:0] edges [15] = '{32'h0007FFFF, 32'h00080000,
        32'h0009FFFF, 32'h000A0000, 32'h000BFFFF, 32'h000C0000,
        32'h000C3FFF, 32'h000C4000, 32'h000EFFFF, 32'h000F0000,
        32'h000FFFFF, 32'h00100000, 32'h00F00000, 32'h00FFFFFF,
        32'h01000000};
    lrsd_decode lrsd_decode_inst (.core_clk(core_clk), .rst(rst),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .vga_to_agp(vga_to_agp),
        .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .req_smm(req_smm), .req_code(req_code),
        .req_from_host(req_from_host), .rsp_valid(rsp_valid),
        .rsp_route(rsp_route));
    lrsd_host_model lrsd_host_model_inst (.core_clk(core_clk),
        .rsp_valid(rsp_valid), .rsp_route(rsp_route),
        .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .req_smm(req_smm), .req_code(req_code),
        .req_from_host(req_from_host));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic mirror_reset();
        hole = 8'h00;
        smc = 8'h02;
        foreach (attr[i]) attr[i] = 8'h00;
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
        if (a >= 8'h90 && a <= 8'h96) attr[a - 8'h90] = d & 8'h33;
        if (a == 8'h97) hole = d & 8'h80;
        if (a == 8'h9D && smc[4]) smc[5] = d[5];
        else if (a == 8'h9D) smc = {1'b0, d[6] & ~d[4], d[5:3], 3'h2};
    endtask
    task automatic cfg_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge core_clk);
        cfg_rd <= 1'b0;
        @(posedge core_clk);
        `CHK("cfg_rdata", e, cfg_rdata)
    endtask
    task automatic check_regs();
        for (int i = 0; i < 7; i++) cfg_check(8'h90 + 8'(i), attr[i]);
        cfg_check(8'h97, hole);
        cfg_check(8'h9D, smc);
        cfg_check(8'h5A, 8'h00);
    endtask
    function automatic lrsd_pkg::lrsd_route_t exp_route(
            input logic [31:0] a, input logic [3:0] f);
        logic wr, smm, code, host, vis;
        logic [3:0] nib;
        int s;
        {wr, smm, code, host} = f;
        vis = smc[3] && ((smc[6] && !smc[4]) || (smm && (code || !smc[5])));
        if (a <= 32'h0007FFFF) return lrsd_pkg::LRSD_DRAM;
        if (a <= 32'h0009FFFF) return hole[7] ? lrsd_pkg::LRSD_PCI
            : lrsd_pkg::LRSD_DRAM;
        if (a <= 32'h000BFFFF) begin
            if (!host) return smc[3] ? lrsd_pkg::LRSD_REFUSE
                : lrsd_pkg::LRSD_PCI;
            if (vis) return lrsd_pkg::LRSD_DRAM;
            return vga_to_agp ? lrsd_pkg::LRSD_AGP : lrsd_pkg::LRSD_PCI;
        end
        if (a <= 32'h000FFFFF) begin
            if (!host) return lrsd_pkg::LRSD_DRAM;
            s = int'((a - 32'h000C0000) >> 14);
            if (s >= 12) nib = attr[0][7:4];
            else nib = s[0] ? attr[s / 2 + 1][7:4] : attr[s / 2 + 1][3:0];
            return nib[wr] ? lrsd_pkg::LRSD_DRAM : lrsd_pkg::LRSD_PCI;
        end
        return (hole[7] && a >= 32'h00F00000 && a <= 32'h00FFFFFF)
            ? lrsd_pkg::LRSD_PCI : lrsd_pkg::LRSD_DRAM;
    endfunction
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        logic [31:0] a;
        logic [7:0] d;
        logic [3:0] f;
        lrsd_pkg::lrsd_route_t r;
        logic ok;
        rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        vga_to_agp = 1'b0;
        bad_count = 0;
        n_compared = 0;
        mirror_reset();
        void'($urandom(32'hB47A9D06));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        check_regs();
        for (int i = 0; i < 800; i++) begin
            if (i == 500) cfg_write(8'h9D, 8'h18);
            if (i % 4 == 0) begin
                d = 8'($urandom);
                // Lock is set once only, so early runs keep it clear
                if (i < 500) d[4] = 1'b0;
                if (d[6]) d[5] = 1'b0;
                a = 32'($urandom_range(0, 8));
                cfg_write(a == 8 ? 8'h9D : 8'h90 + a[7:0], d);
            end
            if (i % 100 == 99) check_regs();
            vga_to_agp <= 1'($urandom);
            case ($urandom_range(0, 3))
                0: a = $urandom & 32'h000FFFFF;
                1: a = 32'h000A0000 | ($urandom & 32'h0001FFFF);
                2: a = $urandom & 32'h01FFFFFF;
                default: a = edges[$urandom_range(0, 14)];
            endcase
            f = 4'($urandom);
            lrsd_host_model_inst.issue(a, f, r, ok);
            if (!ok) begin
                bad_count++;
                break;
            end
            `CHK("rsp_route", exp_route(a, f), r)
            `CHK("rsp_route", exp_route(a, f), r)
        end
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        mirror_reset();
        check_regs();
        final_report();
    end
endmodule
`default_nettype wire
